// ==== include/ctab_params.svh ====
// Constants for the transmit abort and buffer select block
// Behaviour
// (R1) Abort request held reset in init mode
// (R2) Software sets abort bit for queued buffer
// (R3) Grant abort only before start or after failure
// (R4) Granted abort sets empty, ack, interrupt
// (R5) Software cannot clear request; empty flag clears it
// (R6) Ack reads one only when aborted
// (R7) Ack clears when empty flag clears
// (R8) Ack read-only, held reset in init mode
// (R9) Selection held reset in init mode
// (R10) Lowest set selection bit picks window buffer
// (R11) Selection reads back lowest set bit only
// (R12) Window blocked while selected buffer queued
// (R13) No selection means no window access
// (R14) Software copies empty flags into selection
// (R15) Empty flag set by device, write-one clears
// (R16) Bits seven to three read zero
`ifndef CTAB_PARAMS_SVH
`define CTAB_PARAMS_SVH
`define CTAB_ADDR_W 5
`define CTAB_OFS_FLAG 5'h06
`define CTAB_OFS_TIER 5'h07
`define CTAB_OFS_ARQ 5'h08
`define CTAB_OFS_AAK 5'h09
`define CTAB_OFS_SEL 5'h0A
`define CTAB_OFS_IRQ_STAT 5'h18
`define CTAB_OFS_IRQ_MASK 5'h19
`define CTAB_NBUF 3
`define CTAB_FLAG_RST 3'h7
`define CTAB_ZERO3 3'h0
`define CTAB_PAD_ZERO 5'h00
`define CTAB_RD_UNMAPPED 8'h00
`endif

// ==== include/ctab_pkg.sv ====
// Types shared by the transmit abort and buffer select block
package ctab_pkg;
  // Per-buffer event lines from the protocol engine
  typedef struct packed {
    logic [2:0] tx_done;   // Message sent successfully
    logic [2:0] tx_started; // Message has begun on the bus
    logic [2:0] tx_failed; // Lost arbitration or error
  } ctab_engine_t;
  // Shared window access view
  typedef struct packed {
    logic [2:0] sel_onehot; // Buffer mapped into the window
    logic access_ok; // Window accesses permitted
  } ctab_window_t;
endpackage

// ==== rtl/ctab_core.sv ====
// Transmit abort request, abort acknowledge and buffer selection logic
//
// Decided for this implementation: the address-and-strobe port.
`include "ctab_params.svh"
module ctab_core
  import ctab_pkg::*;
(
  input wire logic core_clk, // 50 MHz clock
  input wire logic rst, // Synchronous active high reset
  input wire logic [`CTAB_ADDR_W-1:0] addr, // Register address
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [7:0] rdata, // Read data, cycle after rd
  input wire logic init_mode_request, // Init mode requested
  input wire logic init_mode_acknowledge, // Init mode entered
  input wire ctab_engine_t engine, // Protocol engine events
  output logic [2:0] abort_pending, // Abort requests to the engine
  output logic [2:0] buffer_empty_flag, // Empty flag per buffer
  output ctab_window_t window, // Shared window selection
  output logic tx_irq, // Transmit empty interrupt
  output logic irq // Event interrupt, level
);
  logic init_mode;
  logic not_init;
  logic [2:0] abort_request_bits;
  logic [2:0] abort_acknowledge_bits;
  logic [2:0] sel_raw;
  logic [2:0] sel_low;
  logic [2:0] tx_ie;
  logic [2:0] grant;
  logic [2:0] empty_clr;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  logic [1:0] ev;
  logic wr_flag;
  logic wr_arq;
  logic wr_sel;
  logic wr_tier;
  logic [2:0] empty_prev;

  // Init mode needs both request and acknowledge
  assign init_mode = init_mode_request & init_mode_acknowledge;
  assign not_init = ~init_mode_request & ~init_mode_acknowledge;

  // Write decode; flag, enable, request and selection writes only land while init request and acknowledge are both low
  assign wr_flag = wr && not_init && (addr == `CTAB_OFS_FLAG); // R15
  assign wr_tier = wr && not_init && (addr == `CTAB_OFS_TIER);
  assign wr_arq = wr && not_init && (addr == `CTAB_OFS_ARQ); // R1
  assign wr_sel = wr && not_init && (addr == `CTAB_OFS_SEL); // R9

  // Grant only for queued buffers not yet started or that failed
  generate
    for (genvar i = 0; i < `CTAB_NBUF; i++) begin : g_buf
      assign grant[i] = abort_request_bits[i] && !buffer_empty_flag[i] &&
                        !engine.tx_done[i] &&
                        (!engine.tx_started[i] || engine.tx_failed[i]); // R3
    end
  endgenerate

  assign empty_clr = wr_flag ? wdata[2:0] : `CTAB_ZERO3;
  assign abort_pending = abort_request_bits;

  // Empty flags: device set wins over software clear
  always_ff @(posedge core_clk) begin
    if (rst || init_mode) begin
      buffer_empty_flag <= `CTAB_FLAG_RST;
    end else begin
      buffer_empty_flag <= (buffer_empty_flag & ~empty_clr) | engine.tx_done | grant; // R15 R4
    end
  end

  // Interrupt enables for the empty flags
  always_ff @(posedge core_clk) begin
    if (rst || init_mode) begin
      tx_ie <= `CTAB_ZERO3;
    end else if (wr_tier) begin
      tx_ie <= wdata[2:0];
    end
  end

  // Abort requests: software sets only, empty flag clears
  always_ff @(posedge core_clk) begin
    if (rst || init_mode) begin
      abort_request_bits <= `CTAB_ZERO3; // R1
    end else begin
      abort_request_bits <= (abort_request_bits | (wr_arq ? wdata[2:0] : `CTAB_ZERO3))
                            & ~(engine.tx_done | grant | buffer_empty_flag); // R5
    end
  end

  // Acknowledge: set on grant, cleared by send or when flag is cleared
  always_ff @(posedge core_clk) begin
    if (rst || init_mode) begin
      abort_acknowledge_bits <= `CTAB_ZERO3; // R8
    end else begin
      abort_acknowledge_bits <= (abort_acknowledge_bits & ~empty_clr & ~engine.tx_done)
                                | grant; // R4 R6 R7
    end
  end

  // Selection register keeps the raw written value
  always_ff @(posedge core_clk) begin
    if (rst || init_mode) begin
      sel_raw <= `CTAB_ZERO3; // R9
    end else if (wr_sel) begin
      sel_raw <= wdata[2:0];
    end
  end

  // Lowest set bit wins; ANDing with the two's complement keeps it one-hot
  assign sel_low = sel_raw & (~sel_raw + 3'h1); // R10

  // Window open only when a buffer is selected and it is free
  assign window.sel_onehot = sel_low; // R10
  assign window.access_ok = |(sel_low & buffer_empty_flag); // R12 R13

  // Transmit interrupt from enabled empty flags
  assign tx_irq = |(buffer_empty_flag & tx_ie); // R4

  // Sticky events: bit0 abort granted, bit1 message sent
  assign ev = {|engine.tx_done, |grant};
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_stat <= 2'h0;
    end else begin
      irq_stat <= (irq_stat & ~((wr && addr == `CTAB_OFS_IRQ_STAT) ? wdata[1:0] : 2'h0)) | ev;
    end
  end

  // Mask register for the event interrupt
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_mask <= 2'h0;
    end else if (wr && addr == `CTAB_OFS_IRQ_MASK) begin
      irq_mask <= wdata[1:0];
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // Read data one cycle after the strobe; upper bits read zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata <= `CTAB_RD_UNMAPPED;
    end else if (rd) begin
      if (addr == `CTAB_OFS_FLAG) begin
        rdata <= {`CTAB_PAD_ZERO, buffer_empty_flag};
      end else if (addr == `CTAB_OFS_TIER) begin
        rdata <= {`CTAB_PAD_ZERO, tx_ie};
      end else if (addr == `CTAB_OFS_ARQ) begin
        rdata <= {`CTAB_PAD_ZERO, abort_request_bits}; // R16
      end else if (addr == `CTAB_OFS_AAK) begin
        rdata <= {`CTAB_PAD_ZERO, abort_acknowledge_bits}; // R8 R16
      end else if (addr == `CTAB_OFS_SEL) begin
        rdata <= {`CTAB_PAD_ZERO, sel_low}; // R11 R16
      end else if (addr == `CTAB_OFS_IRQ_STAT) begin
        rdata <= {6'h00, irq_stat};
      end else if (addr == `CTAB_OFS_IRQ_MASK) begin
        rdata <= {6'h00, irq_mask};
      end else begin
        rdata <= `CTAB_RD_UNMAPPED;
      end
    end else begin
      rdata <= `CTAB_RD_UNMAPPED;
    end
  end

  // Helper: previous empty flags for edge checks
  always_ff @(posedge core_clk) begin
    if (rst) begin
      empty_prev <= `CTAB_FLAG_RST;
    end else begin
      empty_prev <= buffer_empty_flag;
    end
  end

  sequence s_grant0;
    grant[0] && !init_mode;
  endsequence

  property p_init_arq;
    @(posedge core_clk) disable iff (rst) init_mode |=> abort_request_bits == 3'h0;
  endproperty
  a_init_arq: assert property (p_init_arq) else $error("abort request not held in init"); // R1

  property p_grant_cond;
    @(posedge core_clk) disable iff (rst)
      grant[0] |-> !engine.tx_started[0] || engine.tx_failed[0];
  endproperty
  a_grant_cond: assert property (p_grant_cond) else $error("abort granted mid send"); // R3

  property p_grant_effect;
    @(posedge core_clk) disable iff (rst)
      s_grant0 ##1 !init_mode |-> buffer_empty_flag[0] && abort_acknowledge_bits[0];
  endproperty
  a_grant_effect: assert property (p_grant_effect) else $error("grant lacked flag or ack"); // R4

  property p_arq_clear;
    @(posedge core_clk) disable iff (rst)
      buffer_empty_flag[1] && !wr_arq |=> !abort_request_bits[1];
  endproperty
  a_arq_clear: assert property (p_arq_clear) else $error("request not cleared by empty"); // R5

  property p_ack_sent;
    @(posedge core_clk) disable iff (rst)
      engine.tx_done[2] && !grant[2] |=> !abort_acknowledge_bits[2];
  endproperty
  a_ack_sent: assert property (p_ack_sent) else $error("ack set on sent message"); // R6

  property p_ack_clear;
    @(posedge core_clk) disable iff (rst)
      empty_prev[0] && !buffer_empty_flag[0] |-> !abort_acknowledge_bits[0];
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("ack survived flag clear"); // R7

  property p_init_sel;
    @(posedge core_clk) disable iff (rst) init_mode |=> sel_raw == 3'h0 && !window.access_ok;
  endproperty
  a_init_sel: assert property (p_init_sel) else $error("selection not held in init"); // R9

  property p_sel_low;
    @(posedge core_clk) disable iff (rst)
      sel_raw[0] |-> window.sel_onehot == 3'h1;
  endproperty
  a_sel_low: assert property (p_sel_low) else $error("lowest bit not selected"); // R10

  property p_sel_read;
    @(posedge core_clk) disable iff (rst)
      rd && addr == `CTAB_OFS_SEL ##0 sel_raw == 3'h6 ##1 1'b1 |-> rdata == 8'h02;
  endproperty
  a_sel_read: assert property (p_sel_read) else $error("selection readback wrong"); // R11

  property p_block;
    @(posedge core_clk) disable iff (rst)
      |(sel_low & ~buffer_empty_flag) || sel_low == 3'h0 |-> !window.access_ok;
  endproperty
  a_block: assert property (p_block) else $error("window open while blocked"); // R12 R13

  property p_hi_zero;
    @(posedge core_clk) disable iff (rst) rd && addr == `CTAB_OFS_AAK |=> rdata[7:3] == 5'h00;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper bits not zero"); // R16

  property p_flag_set;
    @(posedge core_clk) disable iff (rst)
      engine.tx_done[1] && !init_mode ##1 !init_mode |-> buffer_empty_flag[1];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("empty flag not set after send"); // R15

  // Acknowledge register is cleared while init mode holds
  property p_init_ack;
    @(posedge core_clk) disable iff (rst)
      init_mode |=> abort_acknowledge_bits == 3'h0;
  endproperty
  a_init_ack: assert property (p_init_ack) else $error("ack not held in init"); // R8

  // Flags come back to all empty in init mode
  property p_init_flag;
    @(posedge core_clk) disable iff (rst)
      init_mode |=> buffer_empty_flag == `CTAB_FLAG_RST;
  endproperty
  a_init_flag: assert property (p_init_flag) else $error("flags not held in init"); // R15

  // A pending request survives until its buffer is emptied
  property p_arq_keep;
    @(posedge core_clk) disable iff (rst)
      abort_request_bits[0] && !buffer_empty_flag[0] && !grant[0] && !engine.tx_done[0]
      && !init_mode |=> abort_request_bits[0];
  endproperty
  a_arq_keep: assert property (p_arq_keep) else $error("request lost while queued"); // R5

  // A write while init request and acknowledge are both low sets the request of a queued buffer
  property p_arq_set;
    @(posedge core_clk) disable iff (rst)
      wr_arq && wdata[1] && !buffer_empty_flag[1] && !engine.tx_done[1] |=> abort_request_bits[1];
  endproperty
  a_arq_set: assert property (p_arq_set) else $error("request write not taken"); // R2

  // Software has no way to clear an acknowledge bit directly
  property p_ack_hold;
    @(posedge core_clk) disable iff (rst)
      abort_acknowledge_bits[1] && !empty_clr[1] && !engine.tx_done[1] && !init_mode
      |=> abort_acknowledge_bits[1];
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack lost without flag clear"); // R8

  // A granted abort drops its own request on the next edge
  property p_grant_drop;
    @(posedge core_clk) disable iff (rst)
      s_grant0 |=> !abort_request_bits[0];
  endproperty
  a_grant_drop: assert property (p_grant_drop) else $error("request kept after grant"); // R5

  // An acknowledge bit only ever rises through a grant
  property p_ack_origin;
    @(posedge core_clk) disable iff (rst)
      !abort_acknowledge_bits[1] && !grant[1] |=> !abort_acknowledge_bits[1];
  endproperty
  a_ack_origin: assert property (p_ack_origin) else $error("ack set without grant"); // R6

  // No grant while a message is on the bus and has not failed
  property p_no_grant_busy;
    @(posedge core_clk) disable iff (rst)
      engine.tx_started[2] && !engine.tx_failed[2] |-> !grant[2];
  endproperty
  a_no_grant_busy: assert property (p_no_grant_busy) else $error("grant during send"); // R3

  // Grants only for queued buffers with a pending request
  property p_grant_queued;
    @(posedge core_clk) disable iff (rst)
      grant[1] |-> !buffer_empty_flag[1] && abort_request_bits[1];
  endproperty
  a_grant_queued: assert property (p_grant_queued) else $error("grant on idle buffer"); // R3

  // Writing one clears a flag when no set event collides with it
  property p_flag_clr;
    @(posedge core_clk) disable iff (rst)
      wr_flag && wdata[2] && !engine.tx_done[2] && !grant[2] |=> !buffer_empty_flag[2];
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag write one ignored"); // R15

  // Writing zero leaves a set flag alone
  property p_flag_keep;
    @(posedge core_clk) disable iff (rst)
      buffer_empty_flag[0] && !empty_clr[0] |=> buffer_empty_flag[0];
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("flag dropped without write"); // R15

  // Selection takes the written low bits while init request and acknowledge are both low
  property p_sel_write;
    @(posedge core_clk) disable iff (rst)
      wr_sel |=> sel_raw == $past(wdata[2:0]);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("selection write lost"); // R9

  // Selection holds when neither written nor in init mode
  property p_sel_hold;
    @(posedge core_clk) disable iff (rst)
      !wr_sel && !init_mode |=> $stable(sel_raw);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("selection changed unasked"); // R9

  // At most one buffer is ever mapped into the window
  property p_onehot;
    @(posedge core_clk) disable iff (rst)
      1'b1 |-> $onehot0(window.sel_onehot);
  endproperty
  a_onehot: assert property (p_onehot) else $error("window maps several buffers"); // R10
endmodule

// ==== sim/test_can_tx_abort_and_buffer_select.sv ====
// Self-checking bench for the transmit abort and buffer select block
`include "ctab_params.svh"
module test_can_tx_abort_and_buffer_select
  import ctab_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst, wr, rd, init_mode_request, init_mode_acknowledge, tx_irq, irq, i0, i1;
  logic [4:0] addr;
  logic [7:0] wdata, rdata, v;
  logic [2:0] abort_pending, buffer_empty_flag;
  ctab_engine_t engine;
  ctab_window_t window;
  logic [31:0] seed = 32'h0682;
  int bad_count = 0;
  int checks_done = 0;

  ctab_core uut (.core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .init_mode_request(init_mode_request),
    .init_mode_acknowledge(init_mode_acknowledge), .engine(engine),
    .abort_pending(abort_pending), .buffer_empty_flag(buffer_empty_flag), .window(window),
    .tx_irq(tx_irq), .irq(irq));

  // 50 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Repeatable stimulus source
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // Expected window pick: lowest set bit only
  function automatic logic [2:0] lowb(input logic [2:0] s);
    return s & (~s + 3'h1);
  endfunction

  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write; the trailing delay lets the edge's updates settle
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
    #1;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [4:0] a, output logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Bounded wait for a buffer to be flagged empty
  task automatic wait_flag(input int b);
    for (int i = 0; i < 8; i++) begin
      if (buffer_empty_flag[b] === 1'b1) return;
      @(posedge core_clk);
      #1;
    end
    bad_count++;
    $display("wrong value at %0t: empty flag never set", $time);
    final_report();
  endtask

  // Watchdog against a hung sequence
  initial begin
    repeat (5000) @(posedge core_clk);
    bad_count++;
    $display("wrong value at %0t: run timed out", $time);
    final_report();
  end

  initial begin
    rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 5'h00; wdata = 8'h00; engine = '0;
    init_mode_request = 1'b0; init_mode_acknowledge = 1'b0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    rd_reg(`CTAB_OFS_FLAG, v); chk(v, 8'h07);
    rd_reg(`CTAB_OFS_ARQ, v); chk(v, 8'h00);
    rd_reg(`CTAB_OFS_AAK, v); chk(v, 8'h00);
    rd_reg(5'h1F, v); chk(v, 8'h00);
    // Random selections, upper bits included; all buffers empty here
    for (int k = 0; k < 12; k++) begin
      seed = xs(seed);
      wr_reg(`CTAB_OFS_SEL, seed[7:0]);
      rd_reg(`CTAB_OFS_SEL, v); chk(v, {5'h00, lowb(seed[2:0])});
      chk({4'h0, window}, {4'h0, lowb(seed[2:0]), |seed[2:0]});
    end
    // Init mode holds selection at reset and drops writes
    init_mode_request <= 1'b1;
    init_mode_acknowledge <= 1'b1;
    wr_reg(`CTAB_OFS_SEL, 8'h04);
    rd_reg(`CTAB_OFS_SEL, v); chk(v, 8'h00);
    init_mode_request <= 1'b0;
    init_mode_acknowledge <= 1'b0;
    repeat (2) @(posedge core_clk);
    wr_reg(`CTAB_OFS_TIER, 8'h07);
    wr_reg(`CTAB_OFS_SEL, 8'h01);
    wr_reg(`CTAB_OFS_FLAG, 8'h07);
    chk({7'h0, window.access_ok}, 8'h00);
    // Abort of buffer 0 while it is on the bus must wait
    engine.tx_started[0] <= 1'b1;
    wr_reg(`CTAB_OFS_ARQ, 8'h01);
    repeat (3) @(posedge core_clk);
    #1;
    chk({2'h0, abort_pending, buffer_empty_flag}, 8'h08);
    wr_reg(`CTAB_OFS_ARQ, 8'h00); chk({5'h00, abort_pending}, 8'h01);
    engine.tx_failed[0] <= 1'b1;
    @(posedge core_clk);
    engine.tx_failed[0] <= 1'b0;
    engine.tx_started[0] <= 1'b0;
    wait_flag(0);
    chk({5'h00, abort_pending}, 8'h00);
    chk({7'h0, tx_irq}, 8'h01);
    rd_reg(`CTAB_OFS_AAK, v); chk(v, 8'h01);
    // Sticky status, mask and write-one clear
    rd_reg(`CTAB_OFS_IRQ_STAT, v); chk({7'h0, v[0]}, 8'h01);
    wr_reg(`CTAB_OFS_IRQ_MASK, 8'hFF);
    i1 = irq;
    wr_reg(`CTAB_OFS_IRQ_MASK, 8'h00);
    i0 = irq;
    chk({7'h0, i1 ^ i0}, 8'h01);
    wr_reg(`CTAB_OFS_IRQ_STAT, 8'hFF);
    rd_reg(`CTAB_OFS_IRQ_STAT, v); chk(v, 8'h00);
    // Buffer 1 sent normally: no acknowledge
    engine.tx_done[1] <= 1'b1;
    @(posedge core_clk);
    engine.tx_done[1] <= 1'b0;
    wait_flag(1);
    rd_reg(`CTAB_OFS_AAK, v); chk(v, 8'h01);
    // Buffer 2 aborted before start
    wr_reg(`CTAB_OFS_ARQ, 8'h04);
    wait_flag(2);
    rd_reg(`CTAB_OFS_AAK, v); chk(v, 8'h05);
    wr_reg(`CTAB_OFS_AAK, 8'h00);
    rd_reg(`CTAB_OFS_AAK, v); chk(v, 8'h05);
    wr_reg(`CTAB_OFS_FLAG, 8'h01);
    rd_reg(`CTAB_OFS_AAK, v); chk(v, 8'h04);
    rd_reg(`CTAB_OFS_ARQ, v); chk(v, 8'h00);
    // Next free buffer: copy the flags into the selection
    rd_reg(`CTAB_OFS_FLAG, v); chk(v, 8'h06);
    wr_reg(`CTAB_OFS_SEL, v);
    rd_reg(`CTAB_OFS_SEL, v); chk(v, 8'h02);
    chk({7'h0, window.access_ok}, 8'h01);
    final_report();
  end
endmodule
